// ### include/dgc_params.svh
// Offsets, field positions, reset values and constants of the DMA global control
`ifndef DGC_PARAMS_SVH
`define DGC_PARAMS_SVH

`define DGC_OFF_OPCTL     12'h000
`define DGC_OFF_CHEN      12'h004
`define DGC_OFF_TEND      12'h008
`define DGC_OFF_SRC       12'h00c
`define DGC_OFF_MODE      12'h010
`define DGC_OFF_STAT      12'h014

`define DGC_OPCTL_RESET   32'h0000_0000
`define DGC_OPCTL_WMASK   32'h0000_c307
`define DGC_BIT_ODM       15
`define DGC_BIT_EIGHT     14
`define DGC_BIT_PRHI      9
`define DGC_BIT_PRLO      8
`define DGC_BIT_AE        2
`define DGC_BIT_NMI_SEEN_FLAG      1
`define DGC_BIT_DME       0

`define DGC_WORD_SZ_HI    63
`define DGC_WORD_SZ_LO    61
`define DGC_WORD_TAG_HI   59
`define DGC_WORD_TAG_LO   58
`define DGC_WORD_KIND_HI  57
`define DGC_WORD_KIND_LO  56
`define DGC_WORD_NIB_HI   55
`define DGC_WORD_NIB_LO   52

`define DGC_SZ_UPPER      3'h5
`define DGC_SZ_CLEAR_ALL  3'h6
`define DGC_KIND_CLR_ALL  2'h2
`define DGC_KIND_CLR_ONE  2'h3
`define DGC_TAG_CLEAR     2'h0
`define DGC_NIB_CH0       4'h1
`define DGC_NIB_CH7       4'h8

`define DGC_SRC_AUTO      2'h0
`define DGC_SRC_PIN       2'h1
`define DGC_SRC_PERIPH    2'h2

`define DGC_ORDER_FIXED   24'hfac688
`define DGC_ORDER_CH1LOW  24'h3f58d0
`define DGC_ORDER_CH2HIGH 24'hfac642
`define DGC_PR_RROBIN     2'h3

`endif

// ### include/dgc_pkg.sv
// Types shared by the DMA global control block
package dgc_pkg;

  typedef enum logic [1:0] {
    DGC_IDLE,
    DGC_ACK,
    DGC_BUSY
  } dgc_fsm_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        odm;
    logic        eight;
    logic [1:0]  pr;
    logic        ae;
    logic        nmi_seen_flag;
    logic        master_enable;
    logic        ae_armed;
    logic        nmi_seen_flag_armed;
    logic [7:0]  de;
    logic [7:0]  te;
    logic [7:0]  dual;
    logic [7:0]  burst;
    logic [15:0] src;
    logic [7:0]  pend;
    dgc_fsm_t    st;
    logic [2:0]  cur;
    logic [2:0]  last;
    logic        grant;
    logic        ack_n;
    logic [1:0]  tag_out;
    logic        bus_free_n;
    logic [2:0]  nmi_sync;
    logic        nmi_lvl;
    logic        nmi_prev;
    logic [2:0]  rq0_sync;
    logic        rq0_lvl_n;
    logic [2:0]  rq1_sync;
    logic        rq1_lvl_n;
  } dgc_regs_t;

endpackage

// ### design/dgc_top.sv
// DMA global control, channel enabling, arbitration and on-demand requests
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "dgc_params.svh"

// What this block does
// - Operation register clears to zero on reset and holds otherwise.
// - Unused operation bits read zero; software writes zero there.
// - Bit 15 selects on-demand mode driven by external request words.
// - Bit 14 picks four or eight on-demand channels; four rejects 4-7.
// - Eight channels: tag picks 0-3, or 4-7 when size code is 101.
// - Request word fields: size, direction, tag, kind, count, address.
// - Address error sets bit 2, stops all; clear by 0 after reading 1.
// - NMI sets bit 1 always, stops all; clear by 0 after reading 1.
// - Bit 0 master enable; channel runs only with both enables set.
// - Transfer withheld while end flag, no enable, NMI or error flag.
// - Normal mode runs eight channels; pins request only channels 0, 1.
// - Transfers start when enabled, by priority, stop at transfer end.
// - Requests auto, pin or peripheral; single/dual, burst/cycle steal.
// - Four on-demand channels: channel told on the two tag outputs.
// - Eight channels: third bit on bus-free pin with acknowledge.
// - Bus-free pin means available unless acknowledge is asserted in eight-channel mode.
// - Tag 00, kind 10, size 110 clears queues 1-7 and channel 0 flag.
// - Eight channels, kind 11: nibble 1-8 clears one queue; four prohibits.
// - End flag set when count completes, not on early stop.
module dgc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nmi_in,
  input  wire logic        address_error_in,
  input  wire logic        external_request_in_n,
  input  wire logic        external_request_ch1_n,
  input  wire logic [7:0]  periph_request,
  input  wire logic        request_word_valid,
  input  wire logic [63:0] request_word,
  input  wire logic        unit_done,
  input  wire logic [7:0]  count_done,
  input  wire logic        data_bus_ready,
  output logic             grant_valid,
  output logic      [2:0]  grant_channel,
  output logic             grant_dual,
  output logic             grant_burst,
  output logic             transfer_acknowledge_n,
  output logic      [1:0]  channel_tag,
  output logic             bus_free_indicator_n,
  output logic             address_error_irq
);

  dgc_pkg::dgc_regs_t r_reg;
  dgc_pkg::dgc_regs_t r_next;

  // Highest priority first: returns {found, channel}
  function automatic logic [3:0] dgc_pick(
    input logic [7:0] req,
    input logic [1:0] pr,
    input logic [2:0] last
  );
    logic [3:0]  res;
    logic [23:0] ord;
    logic [2:0]  ch;
    res = 4'h0;
    case (pr)
      2'h0:    ord = `DGC_ORDER_FIXED;
      2'h1:    ord = `DGC_ORDER_CH1LOW;
      2'h2:    ord = `DGC_ORDER_CH2HIGH;
      default: ord = `DGC_ORDER_FIXED;
    endcase
    for (int k = 7; k >= 0; k--)
    begin
      if (pr == `DGC_PR_RROBIN)
        ch = 3'(last + 3'(k) + 3'h1);
      else
        ch = ord[3*k +: 3];
      if (req[ch])
        res = {1'b1, ch};
    end
    return res;
  endfunction

  function automatic logic dgc_mapped(input logic [11:0] a);
    return a == `DGC_OFF_OPCTL || a == `DGC_OFF_CHEN ||
           a == `DGC_OFF_TEND || a == `DGC_OFF_SRC ||
           a == `DGC_OFF_MODE || a == `DGC_OFF_STAT;
  endfunction

  logic [7:0] chan_ok;
  logic [7:0] chan_req;
  logic [3:0] pick;
  logic [2:0] word_ch;
  logic [1:0] word_tag;
  logic [1:0] word_kind;
  logic [2:0] word_sz;
  logic [3:0] word_nib;
  logic [7:0] clr_q;
  logic [7:0] set_q;
  logic       wr_en;
  logic       rd_en;
  logic [31:0] opctl_view;

  assign word_sz   = request_word[`DGC_WORD_SZ_HI:`DGC_WORD_SZ_LO];
  assign word_tag  = request_word[`DGC_WORD_TAG_HI:`DGC_WORD_TAG_LO];
  assign word_kind = request_word[`DGC_WORD_KIND_HI:`DGC_WORD_KIND_LO];
  assign word_nib  = request_word[`DGC_WORD_NIB_HI:`DGC_WORD_NIB_LO];
  assign wr_en = psel && penable && r_reg.pready && pwrite;
  assign rd_en = psel && penable && r_reg.pready && !pwrite;

  assign opctl_view = {16'h0000, r_reg.odm, r_reg.eight, 4'h0, r_reg.pr,
                       5'h00, r_reg.ae, r_reg.nmi_seen_flag, r_reg.master_enable};

  // Channel selection from a request word
  always_comb
  begin
    word_ch = {1'b0, word_tag};
    if (r_reg.eight && word_sz == `DGC_SZ_UPPER)
      word_ch = {1'b1, word_tag};
  end

  // Queue clear and set decoded from request words
  always_comb
  begin
    clr_q = 8'h00;
    set_q = 8'h00;
    if (request_word_valid && r_reg.odm)
    begin
      if (word_tag == `DGC_TAG_CLEAR && word_kind == `DGC_KIND_CLR_ALL &&
          word_sz == `DGC_SZ_CLEAR_ALL)
        clr_q = 8'hff;
      else if (word_tag == `DGC_TAG_CLEAR &&
               word_kind == `DGC_KIND_CLR_ONE)
      begin
        if (r_reg.eight && word_nib >= `DGC_NIB_CH0 &&
            word_nib <= `DGC_NIB_CH7)
          clr_q[3'(word_nib - 4'h1)] = 1'b1;
      end
      else
        set_q[word_ch] = 1'b1;
    end
  end

  // Enable conditions and request sources per channel
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_chan
      logic pin_req;
      assign chan_ok[gi] = r_reg.master_enable && r_reg.de[gi] && !r_reg.te[gi] &&
                           !r_reg.nmi_seen_flag && !r_reg.ae;
      if (gi == 0)
        assign pin_req = !r_reg.rq0_lvl_n;
      else if (gi == 1)
        assign pin_req = !r_reg.rq1_lvl_n;
      else
        assign pin_req = 1'b0;
      always_comb
      begin
        if (r_reg.odm)
          chan_req[gi] = chan_ok[gi] && r_reg.pend[gi] &&
                         (gi < 4 || r_reg.eight);
        else
        begin
          case (r_reg.src[2*gi +: 2])
            `DGC_SRC_AUTO:   chan_req[gi] = chan_ok[gi];
            `DGC_SRC_PIN:    chan_req[gi] = chan_ok[gi] && pin_req;
            `DGC_SRC_PERIPH: chan_req[gi] = chan_ok[gi] &&
                                            periph_request[gi];
            default:         chan_req[gi] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  assign pick = dgc_pick(chan_req, r_reg.pr, r_reg.last);

  always_comb
  begin
    r_next = r_reg;
    // Pin synchronisers: a change counts when stages two and three agree
    r_next.nmi_sync = {r_reg.nmi_sync[1:0], nmi_in};
    r_next.rq0_sync = {r_reg.rq0_sync[1:0], external_request_in_n};
    r_next.rq1_sync = {r_reg.rq1_sync[1:0], external_request_ch1_n};
    if (r_reg.nmi_sync[2] == r_reg.nmi_sync[1])
      r_next.nmi_lvl = r_reg.nmi_sync[2];
    if (r_reg.rq0_sync[2] == r_reg.rq0_sync[1])
      r_next.rq0_lvl_n = r_reg.rq0_sync[2];
    if (r_reg.rq1_sync[2] == r_reg.rq1_sync[1])
      r_next.rq1_lvl_n = r_reg.rq1_sync[2];
    r_next.nmi_prev = r_reg.nmi_lvl;

    // APB: answer in the access phase that follows each setup phase
    r_next.pready  = psel && !penable;
    r_next.pslverr = psel && !penable && !dgc_mapped(paddr);
    if (psel && !penable)
    begin
      case (paddr)
        `DGC_OFF_OPCTL: r_next.prdata = opctl_view;
        `DGC_OFF_CHEN:  r_next.prdata = {24'h0, r_reg.de};
        `DGC_OFF_TEND:  r_next.prdata = {24'h0, r_reg.te};
        `DGC_OFF_SRC:   r_next.prdata = {16'h0, r_reg.src};
        `DGC_OFF_MODE:  r_next.prdata = {16'h0, r_reg.burst, r_reg.dual};
        `DGC_OFF_STAT:  r_next.prdata = {20'h0, r_reg.cur, r_reg.grant,
                                         r_reg.pend};
        default:        r_next.prdata = 32'h0000_0000;
      endcase
    end

    if (rd_en && paddr == `DGC_OFF_OPCTL)
    begin
      if (r_reg.ae)
        r_next.ae_armed = 1'b1;
      if (r_reg.nmi_seen_flag)
        r_next.nmi_seen_flag_armed = 1'b1;
    end

    if (wr_en)
    begin
      case (paddr)
        `DGC_OFF_OPCTL:
        begin
          r_next.odm   = pwdata[`DGC_BIT_ODM];
          r_next.eight = pwdata[`DGC_BIT_EIGHT];
          r_next.pr    = {pwdata[`DGC_BIT_PRHI], pwdata[`DGC_BIT_PRLO]};
          r_next.master_enable   = pwdata[`DGC_BIT_DME];
          if (!pwdata[`DGC_BIT_AE] && r_reg.ae_armed)
          begin
            r_next.ae       = 1'b0;
            r_next.ae_armed = 1'b0;
          end
          if (!pwdata[`DGC_BIT_NMI_SEEN_FLAG] && r_reg.nmi_seen_flag_armed)
          begin
            r_next.nmi_seen_flag       = 1'b0;
            r_next.nmi_seen_flag_armed = 1'b0;
          end
        end
        `DGC_OFF_CHEN: r_next.de  = pwdata[7:0];
        `DGC_OFF_TEND: r_next.te  = r_reg.te & ~pwdata[7:0];
        `DGC_OFF_SRC:  r_next.src = pwdata[15:0];
        `DGC_OFF_MODE:
        begin
          r_next.dual  = pwdata[7:0];
          r_next.burst = pwdata[15:8];
        end
        default: ;
      endcase
    end

    // Queues: a new request beats a clear in the same cycle
    r_next.pend = (r_reg.pend & ~clr_q) | set_q;

    // Flags set by hardware win over a software clear
    if (r_reg.nmi_lvl && !r_reg.nmi_prev)
      r_next.nmi_seen_flag = 1'b1;
    if (address_error_in && r_reg.grant)
      r_next.ae = 1'b1;

    r_next.ack_n = 1'b1;
    case (r_reg.st)
      dgc_pkg::DGC_IDLE:
      begin
        r_next.grant = 1'b0;
        if (pick[3])
        begin
          r_next.cur  = pick[2:0];
          r_next.last = pick[2:0];
          if (r_reg.odm)
          begin
            r_next.pend[pick[2:0]] = set_q[pick[2:0]];
            r_next.st      = dgc_pkg::DGC_ACK;
            r_next.ack_n   = 1'b0;
            r_next.tag_out = pick[1:0];
          end
          else
          begin
            r_next.st    = dgc_pkg::DGC_BUSY;
            r_next.grant = 1'b1;
          end
        end
      end
      dgc_pkg::DGC_ACK:
      begin
        r_next.st    = dgc_pkg::DGC_BUSY;
        r_next.grant = chan_ok[r_reg.cur];
        if (!chan_ok[r_reg.cur])
          r_next.st = dgc_pkg::DGC_IDLE;
      end
      dgc_pkg::DGC_BUSY:
      begin
        if (!chan_ok[r_reg.cur] ||
            (address_error_in && r_reg.grant) ||
            (r_reg.nmi_lvl && !r_reg.nmi_prev))
        begin
          r_next.st    = dgc_pkg::DGC_IDLE;
          r_next.grant = 1'b0;
        end
        else if (unit_done)
        begin
          if (count_done[r_reg.cur])
          begin
            r_next.te[r_reg.cur] = 1'b1;
            r_next.st    = dgc_pkg::DGC_IDLE;
            r_next.grant = 1'b0;
          end
          else if (!(r_reg.burst[r_reg.cur] && chan_req[r_reg.cur]))
          begin
            r_next.st    = dgc_pkg::DGC_IDLE;
            r_next.grant = 1'b0;
          end
        end
      end
      default:
      begin
        r_next.st    = dgc_pkg::DGC_IDLE;
        r_next.grant = 1'b0;
      end
    endcase

    // Bus-free pin doubles as third channel bit under acknowledge in eight-channel mode
    if (!r_next.ack_n && r_reg.eight)
      r_next.bus_free_n = !r_next.cur[2];
    else
      r_next.bus_free_n = !data_bus_ready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg            <= '0;
      r_reg.st         <= dgc_pkg::DGC_IDLE;
      r_reg.ack_n      <= 1'b1;
      r_reg.bus_free_n <= 1'b1;
      r_reg.nmi_sync   <= 3'h0;
      r_reg.rq0_sync   <= 3'h7;
      r_reg.rq0_lvl_n  <= 1'b1;
      r_reg.rq1_sync   <= 3'h7;
      r_reg.rq1_lvl_n  <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign prdata                 = r_reg.prdata;
  assign pready                 = r_reg.pready;
  assign pslverr                = r_reg.pslverr;
  assign grant_valid            = r_reg.grant;
  assign grant_channel          = r_reg.cur;
  assign grant_dual             = r_reg.dual[r_reg.cur];
  assign grant_burst            = r_reg.burst[r_reg.cur];
  assign transfer_acknowledge_n = r_reg.ack_n;
  assign channel_tag            = r_reg.tag_out;
  assign bus_free_indicator_n   = r_reg.bus_free_n;
  assign address_error_irq      = r_reg.ae;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reserved_zero_a: assert property (
    pready && psel && paddr == `DGC_OFF_OPCTL |->
      prdata[31:16] == 16'h0 && prdata[13:10] == 4'h0 &&
      prdata[7:3] == 5'h0)
    else $error("reserved operation bits not zero");

  // An enable cleared by software ends the grant at the following edge
  grant_enabled_a: assert property (
    grant_valid && !(r_reg.master_enable && r_reg.de[grant_channel]) |=>
      !grant_valid)
    else $error("grant kept without both enables");

  grant_flags_a: assert property (
    $rose(grant_valid) |-> !r_reg.nmi_seen_flag && !r_reg.ae &&
                           !r_reg.te[grant_channel])
    else $error("grant while flag blocks channel");

  ae_no_sw_set_a: assert property (
    $rose(r_reg.ae) |-> $past(address_error_in) && $past(r_reg.grant))
    else $error("address error flag set without error");

  nmi_sets_a: assert property (
    r_reg.nmi_lvl && !r_reg.nmi_prev |=> r_reg.nmi_seen_flag)
    else $error("nmi flag not set");

  four_ch_reject_a: assert property (
    r_reg.odm && !r_reg.eight && grant_valid |-> !grant_channel[2])
    else $error("upper channel served in four channel mode");

  pin_ch_a: assert property (
    grant_valid && !r_reg.odm &&
    r_reg.src[2*grant_channel +: 2] == `DGC_SRC_PIN |-> grant_channel < 3'h2)
    else $error("pin request on channel above one");

  id_bit_a: assert property (
    !transfer_acknowledge_n && r_reg.eight |->
      bus_free_indicator_n == !grant_channel[2])
    else $error("third channel bit wrong");

  ack_then_grant_a: assert property (
    $fell(transfer_acknowledge_n) |=> transfer_acknowledge_n ##0
      (grant_valid || r_reg.st == dgc_pkg::DGC_IDLE))
    else $error("acknowledge not one cycle");

  te_only_done_a: assert property (
    $rose(r_reg.te[grant_channel]) |-> $past(unit_done) &&
      $past(count_done[grant_channel]))
    else $error("end flag set without completion");

  clear_all_a: assert property (
    request_word_valid && r_reg.odm && word_tag == 2'h0 &&
    word_kind == 2'h2 && word_sz == 3'h6 |=> r_reg.pend == 8'h00)
    else $error("clear-all word left queues");

  apb_answer_a: assert property (
    psel && !penable |=> pready)
    else $error("no answer in access phase");

  ddt_grant_c: cover property (!transfer_acknowledge_n ##1 grant_valid);
  rr_c: cover property (r_reg.pr == 2'h3 && grant_valid ##1 !grant_valid
                        ##[1:4] grant_valid);
  nmi_c: cover property (grant_valid ##1 $rose(r_reg.nmi_seen_flag));
  upper_c: cover property (!transfer_acknowledge_n && grant_channel[2]);

endmodule

// ### verification/dgc_ext_dev.sv
// Model of the external device that issues on-demand request words
`timescale 1ns/1ps
module dgc_ext_dev (
  input  wire logic        pclk,
  input  wire logic        eight,
  input  wire logic        transfer_acknowledge_n,
  input  wire logic [1:0]  channel_tag,
  input  wire logic        bus_free_indicator_n,
  output logic             request_word_valid,
  output logic      [63:0] request_word,
  output logic      [2:0]  seen_channel,
  output logic      [7:0]  ack_count
);
  initial
  begin
    request_word_valid = 1'b0;
    request_word       = 64'h0;
    seen_channel       = 3'h0;
    ack_count          = 8'h00;
  end

  // Under acknowledge in eight-channel mode the bus-free pin carries the inverted third bit
  always @(posedge pclk)
    if (transfer_acknowledge_n === 1'b0)
    begin
      seen_channel <= {eight & ~bus_free_indicator_n, channel_tag};
      ack_count    <= ack_count + 8'h01;
    end

  // One word per call; between words the lines show a changed pattern
  task automatic send(input logic [2:0] sz, input logic [1:0] tag,
                      input logic [1:0] kind, input logic [3:0] nib);
    logic [63:0] w;
    w = {sz, 1'b0, tag, kind, nib, 4'h0, 16'h0, 32'h0000_1000};
    @(posedge pclk);
    request_word_valid <= 1'b1;
    request_word       <= w;
    @(posedge pclk);
    request_word_valid <= 1'b0;
    request_word       <= ~w;
  endtask
endmodule

// ### verification/tb.sv
// Self-checking testbench of the DMA global control block
`timescale 1ns/1ps
`include "dgc_params.svh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, nmi_in, address_error_in;
  logic        external_request_in_n, external_request_ch1_n;
  logic [7:0]  periph_request, count_done, ack_count;
  logic        request_word_valid, unit_done, data_bus_ready;
  logic [63:0] request_word;
  logic        grant_valid, grant_dual, grant_burst, eight;
  logic [2:0]  grant_channel, seen_channel, last_exp;
  logic        transfer_acknowledge_n, bus_free_indicator_n;
  logic [1:0]  channel_tag;
  logic        address_error_irq;
  int          errors, n_compared, cyc;

  localparam logic [2:0] ORD [3][8] = '{
    '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7},
    '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1},
    '{3'h2, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7}};
  localparam logic [7:0] MASKS [3] = '{8'h06, 8'h0a, 8'h26};

  dgc_top dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .nmi_in, .address_error_in,
    .external_request_in_n, .external_request_ch1_n, .periph_request,
    .request_word_valid, .request_word, .unit_done, .count_done,
    .data_bus_ready, .grant_valid, .grant_channel, .grant_dual,
    .grant_burst, .transfer_acknowledge_n, .channel_tag,
    .bus_free_indicator_n, .address_error_irq);

  dgc_ext_dev ext (
    .pclk, .eight, .transfer_acknowledge_n, .channel_tag,
    .bus_free_indicator_n, .request_word_valid, .request_word,
    .seen_channel, .ack_count);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      results();
    end
  end

  task automatic chk_reg(input string nm, input logic [31:0] ex,
                         input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [7:0] ex,
                         input logic [7:0] got);
    n_compared++;
    if (got !== ex)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
  endtask

  task automatic wgr(input logic lvl, input int lim, output logic got);
    int n;
    n = 0;
    got = 1'b0;
    while (n < lim && !got)
    begin
      @(posedge pclk);
      n++;
      got = (grant_valid === lvl);
    end
    if (got && lvl)
      last_exp = grant_channel;
  endtask

  task automatic wack(input logic [7:0] k, output logic got);
    int n;
    n = 0;
    got = 1'b0;
    while (n < 20 && !got)
    begin
      @(posedge pclk);
      n++;
      got = (ack_count !== k);
    end
  endtask

  task automatic unit(input logic [7:0] cd);
    @(posedge pclk);
    unit_done  <= 1'b1;
    count_done <= cd;
    @(posedge pclk);
    unit_done  <= 1'b0;
    count_done <= 8'h00;
  endtask

  task automatic queues(input string nm, input logic [7:0] ex);
    logic [31:0] r;
    rd(`DGC_OFF_STAT, r);
    chk_pin(nm, ex, r[7:0]);
  endtask

  function automatic logic [2:0] winner(input logic [7:0] m,
                                        input logic [1:0] pr,
                                        input logic [2:0] last);
    logic [2:0] c;
    logic [2:0] w;
    w = 3'h0;
    for (int k = 7; k >= 0; k--)
    begin
      c = (pr == 2'h3) ? last + 3'(k + 1) : ORD[pr][k];
      if (m[c])
        w = c;
    end
    return w;
  endfunction

  initial
  begin
    logic [31:0] r;
    logic        e;
    logic        got;
    logic [7:0]  k;
    logic [2:0]  w;
    {psel, penable, pwrite, presetn, nmi_in, address_error_in} = 6'h00;
    {paddr, pwdata, periph_request, count_done} = 60'h0;
    {external_request_in_n, external_request_ch1_n} = 2'h3;
    {unit_done, eight, data_bus_ready} = 3'h1;
    {errors, n_compared, cyc} = 96'h0;
    last_exp = 3'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DGC_OFF_OPCTL, r);
    chk_reg("opctl reset", 32'h0, r);
    wr(`DGC_OFF_OPCTL, 32'h0000_c307);
    rd(`DGC_OFF_OPCTL, r);
    chk_reg("opctl mask", 32'h0000_c301, r);
    xfer(1'b0, 12'h018, 32'h0, r, e);
    chk_pin("unmapped err", 8'h01, {7'h0, e});
    chk_reg("unmapped data", 32'h0, r);
    chk_pin("bus free", 8'h00, {7'h0, bus_free_indicator_n});
    data_bus_ready <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_pin("bus busy", 8'h01, {7'h0, bus_free_indicator_n});
    data_bus_ready <= 1'b1;
    wr(`DGC_OFF_OPCTL, 32'h0000_0001);
    wr(`DGC_OFF_SRC, 32'h0000_0005);
    wr(`DGC_OFF_CHEN, 32'h0000_0003);
    external_request_in_n <= 1'b0;
    wgr(1'b1, 30, got);
    chk_pin("pin0 grant", 8'h00, {5'h0, grant_channel});
    unit(8'h01);
    wgr(1'b0, 10, got);
    rd(`DGC_OFF_TEND, r);
    chk_reg("end flag", 32'h1, r);
    wgr(1'b1, 20, got);
    chk_pin("held by end flag", 8'h00, {7'h0, got});
    external_request_in_n  <= 1'b1;
    external_request_ch1_n <= 1'b0;
    wgr(1'b1, 30, got);
    chk_pin("pin1 grant", 8'h01, {5'h0, grant_channel});
    wr(`DGC_OFF_OPCTL, 32'h0);
    wgr(1'b0, 10, got);
    chk_pin("disable stop", 8'h01, {7'h0, got});
    external_request_ch1_n <= 1'b1;
    rd(`DGC_OFF_TEND, r);
    chk_reg("no end flag", 32'h1, r);
    wr(`DGC_OFF_TEND, 32'h0000_00ff);
    wr(`DGC_OFF_SRC, 32'h0000_aaaa);
    wr(`DGC_OFF_CHEN, 32'h0000_00ff);
    for (int p = 0; p < 4; p++)
      for (int m = 0; m < 3; m++)
      begin
        wr(`DGC_OFF_OPCTL, {22'h0, p[1:0], 8'h01});
        w = winner(MASKS[m], p[1:0], last_exp);
        periph_request <= MASKS[m];
        wgr(1'b1, 20, got);
        chk_pin("priority", {5'h0, w}, {5'h0, grant_channel});
        periph_request <= 8'h00;
        unit(8'h00);
        wgr(1'b0, 10, got);
      end
    wr(`DGC_OFF_MODE, 32'h0000_0202);
    periph_request <= 8'h02;
    wgr(1'b1, 20, got);
    chk_pin("mode bits", 8'h03, {6'h0, grant_burst, grant_dual});
    address_error_in <= 1'b1;
    @(posedge pclk);
    address_error_in <= 1'b0;
    wgr(1'b0, 10, got);
    chk_pin("error stop", 8'h01, {7'h0, got});
    chk_pin("error irq", 8'h01, {7'h0, address_error_irq});
    wgr(1'b1, 20, got);
    chk_pin("held by error", 8'h00, {7'h0, got});
    periph_request <= 8'h00;
    wr(`DGC_OFF_OPCTL, 32'h0000_0301);
    rd(`DGC_OFF_OPCTL, r);
    chk_reg("error kept", 32'h0000_0305, r);
    wr(`DGC_OFF_OPCTL, 32'h0000_0301);
    rd(`DGC_OFF_OPCTL, r);
    chk_reg("error cleared", 32'h0000_0301, r);
    nmi_in <= 1'b1;
    repeat (8) @(posedge pclk);
    nmi_in <= 1'b0;
    rd(`DGC_OFF_OPCTL, r);
    chk_reg("nmi set", 32'h0000_0303, r);
    wr(`DGC_OFF_OPCTL, 32'h0000_0303);
    rd(`DGC_OFF_OPCTL, r);
    chk_reg("nmi kept", 32'h0000_0303, r);
    wr(`DGC_OFF_OPCTL, 32'h0000_0301);
    rd(`DGC_OFF_OPCTL, r);
    chk_reg("nmi cleared", 32'h0000_0301, r);
    wr(`DGC_OFF_OPCTL, 32'h0000_c001);
    eight <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      k = ack_count;
      ext.send(c[2] ? 3'h5 : 3'h0, c[1:0], 2'h0, 4'h0);
      wack(k, got);
      chk_pin("told channel", 8'(c), {5'h0, seen_channel});
      wgr(1'b1, 20, got);
      chk_pin("word grant", 8'(c), {5'h0, grant_channel});
      unit(8'h00);
      wgr(1'b0, 10, got);
    end
    wr(`DGC_OFF_OPCTL, 32'h0000_8001);
    eight <= 1'b0;
    k = ack_count;
    ext.send(3'h0, 2'h2, 2'h0, 4'h0);
    wack(k, got);
    chk_pin("four told", 8'h02, {5'h0, seen_channel});
    wgr(1'b1, 20, got);
    unit(8'h00);
    wgr(1'b0, 10, got);
    k = ack_count;
    ext.send(3'h5, 2'h0, 2'h0, 4'h0);
    wack(k, got);
    chk_pin("size ignored", 8'h01, {7'h0, got});
    chk_pin("low told", 8'h00, {5'h0, seen_channel});
    unit(8'h00);
    wgr(1'b0, 10, got);
    wr(`DGC_OFF_CHEN, 32'h0);
    ext.send(3'h0, 2'h1, 2'h0, 4'h0);
    queues("disabled queued", 8'h02);
    ext.send(3'h6, 2'h0, 2'h2, 4'h0);
    queues("clear all", 8'h00);
    ext.send(3'h0, 2'h1, 2'h0, 4'h0);
    ext.send(3'h0, 2'h0, 2'h3, 4'h2);
    queues("four kind11", 8'h02);
    wr(`DGC_OFF_OPCTL, 32'h0000_c001);
    eight <= 1'b1;
    for (int c = 0; c < 8; c++)
      ext.send(c[2] ? 3'h5 : 3'h0, c[1:0], 2'h0, 4'h0);
    k = 8'hff;
    queues("all queued", k);
    wr(`DGC_OFF_OPCTL, 32'h0000_8001);
    wr(`DGC_OFF_CHEN, 32'h0000_00f0);
    wgr(1'b1, 20, got);
    chk_pin("upper held", 8'h00, {7'h0, got});
    wr(`DGC_OFF_CHEN, 32'h0);
    wr(`DGC_OFF_OPCTL, 32'h0000_c001);
    for (int c = 0; c < 8; c++)
    begin
      ext.send(3'h0, 2'h0, 2'h3, 4'(c + 1));
      k[c] = 1'b0;
      queues("one cleared", k);
    end
    wr(`DGC_OFF_OPCTL, 32'h0000_0001);
    ext.send(3'h0, 2'h1, 2'h0, 4'h0);
    queues("mode off", 8'h00);
    results();
  end
endmodule
